// ===== design/ovrd_regs.vh
`ifndef OVRD_REGS_VH
`define OVRD_REGS_VH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OVRD_OFS_LOW_DUR 8'h00
`define OVRD_OFS_HIGH_DUR 8'h04
`define OVRD_OFS_STATUS 8'h08
`define OVRD_OFS_ADDR 8'h0c
`define OVRD_OFS_RATE 8'h10
`define OVRD_OFS_MONITOR 8'h14
`define OVRD_OFS_PASSWORD 8'h18
`define OVRD_OFS_UNLOCK 8'h1c
`define OVRD_OFS_CONTROL 8'h20
`define OVRD_OFS_TEST 8'h24
`define OVRD_OFS_RANGE 8'h28
`define OVRD_OFS_OPTIME 8'h2c
`define OVRD_OFS_IRQ_STAT 8'h30
`define OVRD_OFS_IRQ_EN 8'h34
`define OVRD_OFS_IRQ_CLR 8'h38
`define OVRD_OFS_TIMEOUT 8'h3c
// ----------------------------------------
// Field positions
// ----------------------------------------
`define OVRD_STAT_BLK_LO 0
`define OVRD_STAT_BLK_HI 3
`define OVRD_STAT_MID_LO 4
`define OVRD_STAT_REMOTE 8
`define OVRD_CTRL_CLEAR 0
`define OVRD_CTRL_TEST_EN 1
`define OVRD_IRQ_LOW_OP 0
`define OVRD_IRQ_HIGH_OP 1
`define OVRD_IRQ_BUS_BROKEN 2
`define OVRD_IRQ_CLEARED 3
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define OVRD_RATE_300 3'h0
`define OVRD_RATE_1200 3'h1
`define OVRD_RATE_2400 3'h2
`define OVRD_RATE_4800 3'h3
`define OVRD_RATE_9600 3'h4
`define OVRD_RATE_RST `OVRD_RATE_9600
`define OVRD_FULL_PERCENT 8'h64
`define OVRD_OPTIME_RST 16'h0005
`define OVRD_TIMEOUT_RST 32'h0000_0064
`define OVRD_RANGE_SHORT 2'h0
`define OVRD_RANGE_MID 2'h1
`define OVRD_RANGE_LONG 2'h2
// ----------------------------------------
// Timing
// ----------------------------------------
`define OVRD_CLK_HZ 200000000
// Tick unit of the operate time setting: 10 ms
`define OVRD_TICK_MS 10
`define OVRD_TICK_CYC (`OVRD_CLK_HZ / 1000 * `OVRD_TICK_MS)
`endif

// ===== design/ovrd_top.v
// Contract
// - Low-set start duration percent counter; new start zeroes it; reads 100 after operation.
// - High-set start duration percent counter, same behaviour, separate.
// - Status low digit shows blocking: 0 none, 1 low, 2 high, 3 both.
// - Status second digit always reads zero.
// - Status top digit shows remote reset input: 1 energized, 0 not.
// - Test mode from control register asserts one start or operate signal at a time.
// - Hold bus address; address zero stops serial participation except the remote clear command, which still clears records.
// - Data rate selectable 300/1200/2400/4800/9600 baud, default 9600.
// - Monitor reads zero while bus works; cycles 0..255 while broken.
// - Remote setting changes need the correct password first.
// - Records 1..5 cleared by both buttons together or remote clear command.
// - Records lose content on supply loss and start from zero.
// - Address and password reload from the non-volatile image after supply loss; rate resets to 9600.
// - Operate time range selectable: 0.05-1.00 s, 0.5-10.0 s, 5-100 s.
`include "ovrd_regs.vh"

module ovrd_top #(
   parameter TICK_CYC = `OVRD_TICK_CYC,
   parameter [15:0] NV_ADDR_RST = 16'h0001,
   parameter [15:0] NV_PWD_RST = 16'h0000
) (
   // Clock and reset
   input wire CLK,
   input wire RST,
   // Register port
   input wire [7:0] ADDR,
   input wire [15:0] WDATA,
   input wire WR,
   input wire RD,
   input wire REMOTE,
   output reg [15:0] RDATA,
   // Stage activity from the protection core
   input wire LOW_START,
   input wire LOW_OPERATE,
   input wire HIGH_START,
   input wire HIGH_OPERATE,
   // Pins
   input wire BLOCK_LOW_N,
   input wire BLOCK_HIGH_N,
   input wire REMOTE_RESET,
   input wire BTN_STEP,
   input wire BTN_RESET,
   // Serial link events
   input wire BUS_MSG_VALID,
   input wire CLEAR_RECORDS_COMMAND,
   // Outputs
   output wire SERIAL_ENABLE,
   output reg [2:0] BAUD_SEL,
   output reg [3:0] TEST_DRIVE,
   output reg [1:0] LOW_RANGE,
   output reg [1:0] HIGH_RANGE,
   output wire IRQ
);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   reg [2:0] s0_q;
   reg [2:0] s1_q;
   reg [2:0] s2_q;
   reg [2:0] pin_q;
   reg btn_a_q;
   reg btn_b_q;
   reg btn_c_q;
   reg btn_q;
   wire btn_clear;

   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         s0_q <= 3'h0;
         s1_q <= 3'h0;
         s2_q <= 3'h0;
         pin_q <= 3'h0;
         btn_a_q <= 1'b0;
         btn_b_q <= 1'b0;
         btn_c_q <= 1'b0;
         btn_q <= 1'b0;
      end else begin
         s0_q <= {REMOTE_RESET, ~BLOCK_HIGH_N, ~BLOCK_LOW_N};
         s1_q <= s0_q;
         s2_q <= s1_q;
         btn_a_q <= BTN_STEP & BTN_RESET;
         btn_b_q <= btn_a_q;
         btn_c_q <= btn_b_q;
         if (s1_q == s2_q) begin
            pin_q <= s2_q;
         end
         if (btn_b_q == btn_c_q) begin
            btn_q <= btn_c_q;
         end
      end
   end

   reg btn_prev_q;
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         btn_prev_q <= 1'b0;
      end else begin
         btn_prev_q <= btn_q;
      end
   end
   assign btn_clear = btn_q & ~btn_prev_q;

   // ----------------------------------------
   // Settings (bus address and password from non-volatile image)
   // ----------------------------------------
   reg [7:0] bus_addr_q;
   reg [2:0] rate_q;
   reg [15:0] pwd_q;
   reg unlocked_q;
   reg test_en_q;
   reg [15:0] optime_q;
   reg [31:0] timeout_q;
   reg [3:0] irq_en_q;
   reg [3:0] irq_stat_q;
   reg nv_loaded_q;
   wire remote_ok = ~REMOTE | (unlocked_q & SERIAL_ENABLE);
   wire wr_ok = WR & remote_ok;
   wire rate_legal = (WDATA[2:0] <= `OVRD_RATE_9600);
   wire sw_clear = wr_ok & (ADDR == `OVRD_OFS_CONTROL) & WDATA[`OVRD_CTRL_CLEAR];
   wire clear_rec = btn_clear | CLEAR_RECORDS_COMMAND | sw_clear;

   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         bus_addr_q <= 8'h00;
         rate_q <= `OVRD_RATE_RST;
         pwd_q <= 16'h0000;
         nv_loaded_q <= 1'b0;
         unlocked_q <= 1'b0;
         test_en_q <= 1'b0;
         TEST_DRIVE <= 4'h0;
         LOW_RANGE <= `OVRD_RANGE_SHORT;
         HIGH_RANGE <= `OVRD_RANGE_SHORT;
         optime_q <= `OVRD_OPTIME_RST;
         timeout_q <= `OVRD_TIMEOUT_RST;
         irq_en_q <= 4'h0;
      end else begin
         if (!nv_loaded_q) begin
            // Retained values reload after power returns
            nv_loaded_q <= 1'b1;
            bus_addr_q <= NV_ADDR_RST[7:0];
            pwd_q <= NV_PWD_RST;
         end
         if (WR && REMOTE && SERIAL_ENABLE && ADDR == `OVRD_OFS_UNLOCK) begin
            unlocked_q <= (WDATA == pwd_q);
         end
         if (wr_ok) begin
            if (ADDR == `OVRD_OFS_ADDR) begin
               bus_addr_q <= WDATA[7:0];
            end else if (ADDR == `OVRD_OFS_RATE) begin
               if (rate_legal) begin
                  rate_q <= WDATA[2:0];
               end
            end else if (ADDR == `OVRD_OFS_PASSWORD) begin
               pwd_q <= WDATA;
            end else if (ADDR == `OVRD_OFS_CONTROL) begin
               test_en_q <= WDATA[`OVRD_CTRL_TEST_EN];
               if (!WDATA[`OVRD_CTRL_TEST_EN]) begin
                  TEST_DRIVE <= 4'h0;
               end
            end else if (ADDR == `OVRD_OFS_TEST) begin
               if (test_en_q) begin
                  // One-hot only: one signal at a time
                  case (WDATA[2:0])
                     3'h1: TEST_DRIVE <= 4'h1;
                     3'h2: TEST_DRIVE <= 4'h2;
                     3'h3: TEST_DRIVE <= 4'h4;
                     3'h4: TEST_DRIVE <= 4'h8;
                     default: TEST_DRIVE <= 4'h0;
                  endcase
               end
            end else if (ADDR == `OVRD_OFS_RANGE) begin
               if (WDATA[1:0] != 2'h3) begin
                  LOW_RANGE <= WDATA[1:0];
               end
               if (WDATA[5:4] != 2'h3) begin
                  HIGH_RANGE <= WDATA[5:4];
               end
            end else if (ADDR == `OVRD_OFS_OPTIME) begin
               if (WDATA != 16'h0000) begin
                  optime_q <= WDATA;
               end
            end else if (ADDR == `OVRD_OFS_IRQ_EN) begin
               irq_en_q <= WDATA[3:0];
            end else if (ADDR == `OVRD_OFS_TIMEOUT) begin
               timeout_q <= {16'h0000, WDATA};
            end
         end
      end
   end

   always @* begin
      BAUD_SEL = rate_q;
   end
   assign SERIAL_ENABLE = (bus_addr_q != 8'h00);

   // ----------------------------------------
   // Start duration counters
   // ----------------------------------------
   reg [31:0] tick_q;
   wire tick = (tick_q == TICK_CYC - 1);
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         tick_q <= 32'h0;
      end else if (tick) begin
         tick_q <= 32'h0;
      end else begin
         tick_q <= tick_q + 32'h1;
      end
   end

   // Operate time in ticks (10 ms) per range: 1 unit x scale
   function [23:0] ovrd_span;
      input [1:0] rng;
      input [15:0] t;
      begin
         case (rng)
            `OVRD_RANGE_MID: ovrd_span = {8'h00, t} * 24'd10;
            `OVRD_RANGE_LONG: ovrd_span = {8'h00, t} * 24'd100;
            default: ovrd_span = {8'h00, t};
         endcase
      end
   endfunction

   wire [1:0] st_in = {HIGH_START, LOW_START};
   wire [1:0] op_in = {HIGH_OPERATE, LOW_OPERATE};
   wire [3:0] rng_pair = {HIGH_RANGE, LOW_RANGE};
   wire [15:0] dur_flat;
   wire [1:0] op_rise;

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : stage
         reg st_prev_q;
         reg op_prev_q;
         reg [7:0] pct_q;
         reg [31:0] acc_q;
         wire [31:0] span = {8'h00, ovrd_span(rng_pair[2*g+1:2*g], optime_q)};
         assign dur_flat[8*g+7:8*g] = pct_q;
         assign op_rise[g] = op_in[g] & ~op_prev_q;
         always @(posedge CLK or posedge RST) begin
            if (RST) begin
               st_prev_q <= 1'b0;
               op_prev_q <= 1'b0;
               pct_q <= 8'h00;
               acc_q <= 32'h0;
            end else begin
               st_prev_q <= st_in[g];
               op_prev_q <= op_in[g];
               if (clear_rec) begin
                  pct_q <= 8'h00;
                  acc_q <= 32'h0;
               end else if (op_in[g]) begin
                  pct_q <= `OVRD_FULL_PERCENT;
               end else if (st_in[g] && !st_prev_q) begin
                  pct_q <= 8'h00;
                  acc_q <= 32'h0;
               end else if (st_in[g] && tick && pct_q < 8'h63) begin
                  // Percent = elapsed*100/span, stepped by accumulation
                  if (acc_q + 32'd100 >= span) begin
                     acc_q <= acc_q + 32'd100 - span;
                     pct_q <= pct_q + 8'h01;
                  end else begin
                     acc_q <= acc_q + 32'd100;
                  end
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Bus monitor
   // ----------------------------------------
   reg [31:0] silent_q;
   reg broken_q;
   reg [7:0] mon_q;
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         silent_q <= 32'h0;
         broken_q <= 1'b0;
         mon_q <= 8'h00;
      end else begin
         if (BUS_MSG_VALID && SERIAL_ENABLE) begin
            silent_q <= 32'h0;
            broken_q <= 1'b0;
         end else if (!SERIAL_ENABLE && nv_loaded_q) begin
            broken_q <= 1'b1;
         end else if (tick) begin
            if (silent_q >= timeout_q) begin
               broken_q <= 1'b1;
            end else begin
               silent_q <= silent_q + 32'h1;
            end
         end
         if (broken_q) begin
            mon_q <= mon_q + 8'h01;
         end else begin
            mon_q <= 8'h00;
         end
      end
   end

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   reg broken_prev_q;
   wire [3:0] irq_evt = {clear_rec, broken_q & ~broken_prev_q, op_rise};
   wire [3:0] irq_clr = (wr_ok && ADDR == `OVRD_OFS_IRQ_CLR) ? WDATA[3:0] : 4'h0;
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         broken_prev_q <= 1'b0;
         irq_stat_q <= 4'h0;
      end else begin
         broken_prev_q <= broken_q;
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
      end
   end
   assign IRQ = |(irq_stat_q & irq_en_q);

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   wire [15:0] status = {7'h00, pin_q[2], 4'h0, 2'h0, pin_q[1:0]};
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         RDATA <= 16'h0000;
      end else if (RD) begin
         if (ADDR == `OVRD_OFS_LOW_DUR) begin
            RDATA <= {8'h00, dur_flat[7:0]};
         end else if (ADDR == `OVRD_OFS_HIGH_DUR) begin
            RDATA <= {8'h00, dur_flat[15:8]};
         end else if (ADDR == `OVRD_OFS_STATUS) begin
            RDATA <= status;
         end else if (ADDR == `OVRD_OFS_ADDR) begin
            RDATA <= {8'h00, bus_addr_q};
         end else if (ADDR == `OVRD_OFS_RATE) begin
            RDATA <= {13'h0000, rate_q};
         end else if (ADDR == `OVRD_OFS_MONITOR) begin
            RDATA <= {8'h00, mon_q};
         end else if (ADDR == `OVRD_OFS_CONTROL) begin
            RDATA <= {14'h0000, test_en_q, 1'b0};
         end else if (ADDR == `OVRD_OFS_TEST) begin
            RDATA <= {12'h000, TEST_DRIVE};
         end else if (ADDR == `OVRD_OFS_RANGE) begin
            RDATA <= {10'h000, HIGH_RANGE, 2'h0, LOW_RANGE};
         end else if (ADDR == `OVRD_OFS_OPTIME) begin
            RDATA <= optime_q;
         end else if (ADDR == `OVRD_OFS_IRQ_STAT) begin
            RDATA <= {12'h000, irq_stat_q};
         end else if (ADDR == `OVRD_OFS_IRQ_EN) begin
            RDATA <= {12'h000, irq_en_q};
         end else if (ADDR == `OVRD_OFS_TIMEOUT) begin
            RDATA <= timeout_q[15:0];
         end else begin
            RDATA <= 16'h0000;
         end
      end else begin
         RDATA <= 16'h0000;
      end
   end

endmodule

// ===== testbench/ovrd_rec_monitor.sv
module ovrd_rec_monitor (
   // Clock and reset
   input wire CLK,
   input wire RST,
   // Register port
   input wire [7:0] ADDR,
   input wire [15:0] WDATA,
   input wire WR,
   input wire RD,
   input wire REMOTE,
   input wire [15:0] RDATA,
   // Settings outputs
   input wire SERIAL_ENABLE,
   input wire [2:0] BAUD_SEL,
   input wire [3:0] TEST_DRIVE,
   input wire [1:0] LOW_RANGE,
   input wire [1:0] HIGH_RANGE
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   // ------------------------------
   // Settings
   // ------------------------------
   chk_baud_legal: assert property (BAUD_SEL <= 3'h4)
      else $error("baud select out of range");
   chk_baud_write: assert property (WR && ADDR == 8'h10 && !REMOTE && WDATA <= 16'h0004
      |=> BAUD_SEL == $past(WDATA[2:0])) else $error("baud select not written");
   chk_rate_readback: assert property (RD && ADDR == 8'h10
      |=> RDATA == {13'h0000, $past(BAUD_SEL)}) else $error("rate read mismatch");
   chk_addr_zero: assert property (RD && ADDR == 8'h0c
      |=> (RDATA == 16'h0000) == !SERIAL_ENABLE) else $error("serial enable wrong");
   chk_range_legal: assert property (LOW_RANGE != 2'h3 && HIGH_RANGE != 2'h3)
      else $error("range code 3 seen");
   chk_range_write: assert property (WR && ADDR == 8'h28 && !REMOTE && WDATA[1:0] != 2'h3
      && WDATA[5:4] != 2'h3 |=> {HIGH_RANGE, LOW_RANGE} == $past({WDATA[5:4], WDATA[1:0]}))
      else $error("range not written");
   // ------------------------------
   // Test mode and readback
   // ------------------------------
   chk_test_onehot: assert property ($onehot0(TEST_DRIVE))
      else $error("more than one test drive");
   chk_test_cause: assert property ($rose(|TEST_DRIVE)
      |-> $past(WR) && $past(ADDR) == 8'h24) else $error("test drive without write");
   chk_status_zero: assert property (RD && ADDR == 8'h08
      |=> RDATA[7:4] == 4'h0 && RDATA[15:9] == 7'h00) else $error("status pad not zero");
   chk_dur_limit: assert property (RD && (ADDR == 8'h00 || ADDR == 8'h04)
      |=> RDATA <= 16'h0064) else $error("duration above full");
   cover property (WR && ADDR == 8'h24 ##1 |TEST_DRIVE);
   cover property (RD && ADDR == 8'h00 ##1 RDATA == 16'h0064);
   cover property (!SERIAL_ENABLE);
endmodule

bind ovrd_top ovrd_rec_monitor i_ovrd_rec_monitor (.CLK(CLK), .RST(RST), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .RD(RD), .REMOTE(REMOTE), .RDATA(RDATA),
   .SERIAL_ENABLE(SERIAL_ENABLE), .BAUD_SEL(BAUD_SEL), .TEST_DRIVE(TEST_DRIVE),
   .LOW_RANGE(LOW_RANGE), .HIGH_RANGE(HIGH_RANGE));

// ===== testbench/ovrd_comm_model.sv
module ovrd_comm_model (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Bench control
   input wire talk,
   input wire clr_req,
   // Link events
   output logic msg_valid,
   output logic clr_cmd
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] gap_q;
   // Polls every fourth cycle while talking
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         gap_q <= 2'h0;
         msg_valid <= 1'b0;
         clr_cmd <= 1'b0;
      end else begin
         gap_q <= gap_q + 2'h1;
         msg_valid <= talk && gap_q == 2'h3;
         clr_cmd <= clr_req;
      end
   end
endmodule

// ===== testbench/ovrd_top_tb.sv
module ovrd_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, wr_s, rd_s, remote, lo_n, hi_n, rrst, step, rstb, talk, clr_req;
   logic [7:0] addr;
   logic [15:0] wdata, v, a;
   logic [3:0] stg;
   wire [15:0] rdata;
   wire [2:0] baud;
   wire [3:0] tdrv;
   wire [1:0] lrng, hrng;
   wire ser_en, irq, msg_valid, clr_cmd;
   int errors, n_checks, i, k;

   ovrd_top #(.TICK_CYC(4)) i_ovrd_top (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
      .WR(wr_s), .RD(rd_s), .REMOTE(remote), .RDATA(rdata), .LOW_START(stg[0]),
      .LOW_OPERATE(stg[1]), .HIGH_START(stg[2]), .HIGH_OPERATE(stg[3]), .BLOCK_LOW_N(lo_n),
      .BLOCK_HIGH_N(hi_n), .REMOTE_RESET(rrst), .BTN_STEP(step), .BTN_RESET(rstb),
      .BUS_MSG_VALID(msg_valid), .CLEAR_RECORDS_COMMAND(clr_cmd), .SERIAL_ENABLE(ser_en),
      .BAUD_SEL(baud), .TEST_DRIVE(tdrv), .LOW_RANGE(lrng), .HIGH_RANGE(hrng), .IRQ(irq));
   ovrd_comm_model i_ovrd_comm_model (.clk(clk), .rst(rst), .talk(talk), .clr_req(clr_req),
      .msg_valid(msg_valid), .clr_cmd(clr_cmd));

   // ------------------------------
   // Access tasks
   // ------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] ad, input logic [15:0] d, input logic r);
      @(posedge clk);
      addr <= ad;
      wdata <= d;
      remote <= r;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
      remote <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] ad);
      @(posedge clk);
      addr <= ad;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic rdc(input logic [7:0] ad, input logic [15:0] exp);
      rd(ad);
      chk(v, exp);
   endtask
   task automatic test_done;
      $display("checks=%0d errors=%0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ------------------------------
   // Scenarios
   // ------------------------------
   initial begin
      rst = 1'b1;
      {wr_s, rd_s, remote, step, rstb, clr_req, rrst} = 7'h00;
      {lo_n, hi_n, talk} = 3'h7;
      addr = 8'h00;
      wdata = 16'h0000;
      stg = 4'h0;
      errors = 0;
      n_checks = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      chk(baud, 3'h4);
      rdc(8'h0c, 16'h0001);
      rdc(8'h00, 16'h0000);
      for (i = 0; i < 6; i++) begin
         wr(8'h10, 16'(i), 1'b0);
         chk(baud, (i < 5) ? 3'(i) : 3'h4);
      end
      rdc(8'h10, 16'h0004);
      $display("reset and rate done");
      wr(8'h0c, 16'h0000, 1'b0);
      chk(ser_en, 1'b0);
      rd(8'h14);
      a = v;
      rd(8'h14);
      chk((v - a) & 16'h00ff, 16'h0002);
      wr(8'h0c, 16'h0001, 1'b0);
      chk(ser_en, 1'b1);
      repeat (8) @(posedge clk);
      rdc(8'h14, 16'h0000);
      wr(8'h3c, 16'h0002, 1'b0);
      wr(8'h38, 16'h000f, 1'b0);
      wr(8'h34, 16'h0004, 1'b0);
      chk(irq, 1'b0);
      talk <= 1'b0;
      for (k = 0; k < 100 && irq !== 1'b1; k++) @(posedge clk);
      chk(irq, 1'b1);
      if (k == 100) test_done;
      wr(8'h38, 16'h0004, 1'b0);
      chk(irq, 1'b0);
      talk <= 1'b1;
      repeat (8) @(posedge clk);
      rdc(8'h14, 16'h0000);
      $display("bus monitor done");
      for (i = 0; i < 4; i++) begin
         @(posedge clk);
         lo_n <= !i[0];
         hi_n <= !i[1];
         rrst <= i[0];
         repeat (6) @(posedge clk);
         rdc(8'h08, {7'h00, i[0], 6'h00, i[1:0]});
      end
      $display("status done");
      wr(8'h24, 16'h0001, 1'b0);
      chk(tdrv, 4'h0);
      wr(8'h20, 16'h0002, 1'b0);
      for (i = 1; i < 5; i++) begin
         wr(8'h24, 16'(i), 1'b0);
         chk(tdrv, 4'h1 << (i - 1));
      end
      wr(8'h24, 16'h0000, 1'b0);
      wr(8'h20, 16'h0000, 1'b0);
      for (i = 0; i < 4; i++) begin
         wr(8'h28, 16'(i * 17), 1'b0);
         chk({hrng, lrng}, (i < 3) ? 4'(i * 5) : 4'ha);
      end
      $display("test mode and range done");
      wr(8'h2c, 16'h0064, 1'b0);
      wr(8'h34, 16'h000b, 1'b0);
      for (i = 0; i < 2; i++) begin
         wr(8'h38, 16'h0003, 1'b0);
         @(posedge clk) stg <= 4'h1 << (2 * i);
         @(posedge clk) stg <= 4'h3 << (2 * i);
         repeat (2) @(posedge clk);
         rdc(8'(4 * i), 16'h0064);
         rdc(8'h30, 16'h0001 << i);
         chk(irq, 1'b1);
         wr(8'h38, 16'h0003, 1'b0);
         @(posedge clk) stg <= 4'h0;
         @(posedge clk) stg <= 4'h1 << (2 * i);
         repeat (2) @(posedge clk);
         rdc(8'(4 * i), 16'h0000);
         @(posedge clk) stg <= 4'h3 << (2 * i);
         @(posedge clk) stg <= 4'h0;
      end
      wr(8'h38, 16'h000f, 1'b0);
      @(posedge clk) clr_req <= 1'b1;
      @(posedge clk) clr_req <= 1'b0;
      repeat (3) @(posedge clk);
      rdc(8'h00, 16'h0000);
      rdc(8'h04, 16'h0000);
      chk(irq, 1'b1);
      @(posedge clk) stg <= 4'h3;
      @(posedge clk) stg <= 4'h0;
      rdc(8'h00, 16'h0064);
      @(posedge clk) {step, rstb} <= 2'h3;
      repeat (3) @(posedge clk);
      {step, rstb} <= 2'h0;
      repeat (3) @(posedge clk);
      rdc(8'h00, 16'h0000);
      $display("records done");
      wr(8'h10, 16'h0002, 1'b0);
      wr(8'h18, 16'h00a5, 1'b0);
      wr(8'h10, 16'h0001, 1'b1);
      chk(baud, 3'h2);
      wr(8'h1c, 16'h0011, 1'b1);
      wr(8'h10, 16'h0001, 1'b1);
      chk(baud, 3'h2);
      wr(8'h1c, 16'h00a5, 1'b1);
      wr(8'h10, 16'h0001, 1'b1);
      chk(baud, 3'h1);
      wr(8'h0c, 16'h0000, 1'b0);
      wr(8'h10, 16'h0003, 1'b1);
      chk(baud, 3'h1);
      wr(8'h0c, 16'h0001, 1'b0);
      rdc(8'hfc, 16'h0000);
      $display("password done");
      @(posedge clk) stg <= 4'h3;
      @(posedge clk) stg <= 4'h0;
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      rdc(8'h00, 16'h0000);
      rdc(8'h0c, 16'h0001);
      $display("supply loss done");
      test_done;
   end
endmodule
